// ===== pkg/serial_master_translator_defines.svh
/*
 * Constants for the serial master translator: Modbus opcodes, address
 * arithmetic figures, retry limit and timing.
 * Assumes a 50 MHz module clock and a framer that serialises the query.
 */
// Functional notes
// - In host mode the port holds a 16-bit unsigned register offset, 0 to all ones.
// - The offset is added only to outgoing host-mode master queries, never to slave traffic.
// - Register queries (3, 4, 6, 16) use address = upstream remote address + offset.
// - In gate mode the offset used in every calculation is zero.
// - Addresses generated from slave-side messages use a zero offset.
// - Coil queries (1, 5, 15) start at ((remote + offset - 1) * 16) + 1.
// - Gate mode uses the fixed translation table, host mode the user read and write opcodes.
// - With no valid reply the port waits the retry timeout and sends the same query again.
// - A query goes out at most three times: the first send plus two retries.
// - Full duplex driver mode keeps the transmitter on and the receiver on from the first clock after reset; reset holds both off.
// - Cts_keyed_driver_mode driver mode enables the transmitter only while CTS is asserted.
// - Two-wire driver mode keys the transmitter from CTS and disables reception while sending.
// - Untranslatable upstream commands go out as opcode 17 with one parameter byte 0x01.
`ifndef SERIAL_MASTER_TRANSLATOR_DEFINES_SVH
`define SERIAL_MASTER_TRANSLATOR_DEFINES_SVH

`define SMT_OP_RD_COILS   8'h01
`define SMT_OP_RD_HOLD    8'h03
`define SMT_OP_RD_INPUT   8'h04
`define SMT_OP_WR_COIL    8'h05
`define SMT_OP_WR_REG     8'h06
`define SMT_OP_WR_COILS   8'h0F
`define SMT_OP_WR_REGS    8'h10
`define SMT_OP_ENCAP      8'h11
`define SMT_ENCAP_PARAM   8'h01
`define SMT_NO_PARAM      8'h00
`define SMT_ZERO_OFFSET   16'h0000
`define SMT_ADDR_ONE      16'h0001
`define SMT_COIL_SHIFT    4
`define SMT_MAX_RETRY     2'h2
`define SMT_CLK_NS        32'h14
`define SMT_TICK_NS       32'hF4240
`define SMT_TICK_CYCLES   (`SMT_TICK_NS / `SMT_CLK_NS)

`endif

// ===== pkg/smt_pkg.sv
/*
 * Types shared by the serial master translator files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package smt_pkg;

	typedef enum logic [1:0] {
		always_driven_full_duplex,
		cts_keyed_driver_mode,
		cts_keyed_half_duplex
	} driver_mode_type;

	typedef enum logic [1:0] {
		KIND_READ,
		KIND_WRITE,
		KIND_OTHER
	} kind_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SEND,
		ST_WAIT
	} state_type;

endpackage : smt_pkg

// ===== src/retry_timer.sv
/*
 * Retry timeout timer: counts a timeout given in millisecond ticks.
 * Assumes start_i is a one-cycle pulse; a zero timeout counts as one tick.
 */
`timescale 1ns/1ps
`default_nettype none
`include "serial_master_translator_defines.svh"

module retry_timer #(
	parameter int TICK_CYCLES = `SMT_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// control
	input  wire logic        start_i,
	input  wire logic        stop_i,
	input  wire logic [15:0] timeout_i,
	output logic             expire_o
);

	logic        run_q,  run_d;
	logic [31:0] pre_q,  pre_d;
	logic [15:0] left_q, left_d;
	logic        exp_q,  exp_d;
	logic        tick;

	assign tick     = run_q && (pre_q == 32'(TICK_CYCLES - 1));
	assign expire_o = exp_q;

	always_comb begin
		run_d  = run_q;
		pre_d  = pre_q;
		left_d = left_q;
		exp_d  = 1'b0;
		if (start_i) begin
			run_d  = 1'b1;
			pre_d  = 32'h0;
			left_d = (timeout_i == 16'h0) ? 16'h1 : timeout_i;
		end else if (stop_i) begin
			run_d = 1'b0;
		end else if (run_q) begin
			pre_d = tick ? 32'h0 : pre_q + 32'h1;
			if (tick) begin
				left_d = left_q - 16'h1;
				if (left_q == 16'h1) begin
					run_d = 1'b0;
					exp_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			run_q  <= 1'b0;
			pre_q  <= 32'h0;
			left_q <= 16'h0;
			exp_q  <= 1'b0;
		end else begin
			run_q  <= run_d;
			pre_q  <= pre_d;
			left_q <= left_d;
			exp_q  <= exp_d;
		end
	end

endmodule : retry_timer
`default_nettype wire

// ===== src/serial_master_translator.sv
/*
 * Master-side translator for one serial port: upstream read and write
 * requests become Modbus RTU queries, with retries and line driver keying.
 * Assumes a framer that sends the query fields and reports valid replies,
 * and synchronous configuration inputs held steady during a transaction.
 */
`timescale 1ns/1ps
`default_nettype none
`include "serial_master_translator_defines.svh"

module serial_master_translator #(
	parameter int TICK_CYCLES = `SMT_TICK_CYCLES
) (
	// clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   nrst_i,
	// port configuration
	input  wire logic                   host_mode_i,
	input  wire logic [15:0]            reg_offset_i,
	input  wire logic [7:0]             rd_opcode_i,
	input  wire logic [7:0]             wr_opcode_i,
	input  wire logic [15:0]            retry_timeout_i,
	input  wire smt_pkg::driver_mode_type driver_mode_i,
	// upstream request
	input  wire logic                   req_valid_i,
	output logic                        req_ready_o,
	input  wire smt_pkg::kind_type      req_kind_i,
	input  wire logic                   req_coil_i,
	input  wire logic [15:0]            req_addr_i,
	// upstream completion
	output logic                        done_valid_o,
	output logic                        done_fail_o,
	// query to framer
	output logic                        qry_valid_o,
	input  wire logic                   qry_ready_i,
	output logic [7:0]                  qry_opcode_o,
	output logic [15:0]                 qry_addr_o,
	output logic [7:0]                  qry_param_o,
	output logic [1:0]                  qry_attempt_o,
	// reply from framer
	input  wire logic                   rsp_valid_i,
	input  wire logic                   rsp_ok_i,
	// slave-side address translation
	input  wire logic                   slv_valid_i,
	input  wire logic [15:0]            slv_addr_i,
	output logic                        slv_up_valid_o,
	output logic [15:0]                 slv_up_addr_o,
	// line driver
	input  wire logic                   cts_i,
	input  wire logic                   tx_busy_i,
	output logic                        tx_en_o,
	output logic                        rx_en_o
);

	// ----------------------------------------------------------------
	// opcode selection and address arithmetic
	// ----------------------------------------------------------------
	function automatic logic is_reg_op(input logic [7:0] op);
		is_reg_op = (op == `SMT_OP_RD_HOLD) || (op == `SMT_OP_RD_INPUT) ||
			(op == `SMT_OP_WR_REG) || (op == `SMT_OP_WR_REGS);
	endfunction : is_reg_op

	function automatic logic is_coil_op(input logic [7:0] op);
		is_coil_op = (op == `SMT_OP_RD_COILS) || (op == `SMT_OP_WR_COIL) ||
			(op == `SMT_OP_WR_COILS);
	endfunction : is_coil_op

	logic [7:0]  sel_opcode;
	logic [15:0] eff_offset;
	logic [15:0] sel_addr;
	logic [15:0] sum_addr;

	always_comb begin
		case (req_kind_i)
			smt_pkg::KIND_READ: begin
				if (host_mode_i) begin
					sel_opcode = rd_opcode_i;
				end else begin
					sel_opcode = req_coil_i ? `SMT_OP_RD_COILS : `SMT_OP_RD_HOLD;
				end
			end
			smt_pkg::KIND_WRITE: begin
				if (host_mode_i) begin
					sel_opcode = wr_opcode_i;
				end else begin
					sel_opcode = req_coil_i ? `SMT_OP_WR_COILS : `SMT_OP_WR_REGS;
				end
			end
			default: begin
				sel_opcode = `SMT_OP_ENCAP;
			end
		endcase
	end

	// offset only reaches the outgoing master path, zero in gate mode
	assign eff_offset = host_mode_i ? reg_offset_i : `SMT_ZERO_OFFSET;
	assign sum_addr   = req_addr_i + eff_offset;

	always_comb begin
		if (is_reg_op(sel_opcode)) begin
			sel_addr = sum_addr;
		end else if (is_coil_op(sel_opcode)) begin
			sel_addr = 16'((sum_addr - `SMT_ADDR_ONE) << `SMT_COIL_SHIFT) + `SMT_ADDR_ONE;
		end else begin
			sel_addr = req_addr_i;
		end
	end

	// ----------------------------------------------------------------
	// transaction sequencer
	// ----------------------------------------------------------------
	smt_pkg::state_type state_q, state_d;
	logic [7:0]         op_q,    op_d;
	logic [15:0]        addr_q,  addr_d;
	logic [7:0]         param_q, param_d;
	logic [1:0]         att_q,   att_d;
	logic               done_q,  done_d;
	logic               fail_q,  fail_d;
	logic               timer_start;
	logic               timer_stop;
	logic               timer_expire;
	logic               reply_ok;

	assign reply_ok    = (state_q == smt_pkg::ST_WAIT) && rsp_valid_i && rsp_ok_i;
	assign req_ready_o = (state_q == smt_pkg::ST_IDLE);
	assign qry_valid_o = (state_q == smt_pkg::ST_SEND);
	assign timer_start = qry_valid_o && qry_ready_i;
	assign timer_stop  = reply_ok;

	always_comb begin
		state_d = state_q;
		op_d    = op_q;
		addr_d  = addr_q;
		param_d = param_q;
		att_d   = att_q;
		done_d  = 1'b0;
		fail_d  = fail_q;
		case (state_q)
			smt_pkg::ST_IDLE: begin
				if (req_valid_i) begin
					op_d    = sel_opcode;
					addr_d  = sel_addr;
					param_d = (sel_opcode == `SMT_OP_ENCAP) ? `SMT_ENCAP_PARAM : `SMT_NO_PARAM;
					att_d   = 2'h0;
					state_d = smt_pkg::ST_SEND;
				end
			end
			smt_pkg::ST_SEND: begin
				if (qry_ready_i) begin
					state_d = smt_pkg::ST_WAIT;
				end
			end
			smt_pkg::ST_WAIT: begin
				if (reply_ok) begin
					done_d  = 1'b1;
					fail_d  = 1'b0;
					state_d = smt_pkg::ST_IDLE;
				end else if (timer_expire) begin
					if (att_q == `SMT_MAX_RETRY) begin
						done_d  = 1'b1;
						fail_d  = 1'b1;
						state_d = smt_pkg::ST_IDLE;
					end else begin
						att_d   = att_q + 2'h1;
						state_d = smt_pkg::ST_SEND;
					end
				end
			end
			default: begin
				state_d = smt_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= smt_pkg::ST_IDLE;
			op_q    <= 8'h00;
			addr_q  <= 16'h0000;
			param_q <= 8'h00;
			att_q   <= 2'h0;
			done_q  <= 1'b0;
			fail_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q    <= op_d;
			addr_q  <= addr_d;
			param_q <= param_d;
			att_q   <= att_d;
			done_q  <= done_d;
			fail_q  <= fail_d;
		end
	end

	assign qry_opcode_o  = op_q;
	assign qry_addr_o    = addr_q;
	assign qry_param_o   = param_q;
	assign qry_attempt_o = att_q;
	assign done_valid_o  = done_q;
	assign done_fail_o   = fail_q;

	retry_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_retry_timer (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.start_i   (timer_start),
		.stop_i    (timer_stop),
		.timeout_i (retry_timeout_i),
		.expire_o  (timer_expire)
	);

	// ----------------------------------------------------------------
	// slave-side address, always unbiased
	// ----------------------------------------------------------------
	logic        slv_v_q, slv_v_d;
	logic [15:0] slv_a_q, slv_a_d;

	always_comb begin
		slv_v_d = slv_valid_i;
		slv_a_d = slv_valid_i ? slv_addr_i + `SMT_ZERO_OFFSET : slv_a_q;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			slv_v_q <= 1'b0;
			slv_a_q <= 16'h0000;
		end else begin
			slv_v_q <= slv_v_d;
			slv_a_q <= slv_a_d;
		end
	end

	assign slv_up_valid_o = slv_v_q;
	assign slv_up_addr_o  = slv_a_q;

	// ----------------------------------------------------------------
	// line driver keying
	// ----------------------------------------------------------------
	logic tx_q, tx_d;
	logic rx_q, rx_d;

	always_comb begin
		case (driver_mode_i)
			smt_pkg::always_driven_full_duplex: begin
				tx_d = 1'b1;
				rx_d = 1'b1;
			end
			smt_pkg::cts_keyed_driver_mode: begin
				tx_d = cts_i;
				rx_d = 1'b1;
			end
			smt_pkg::cts_keyed_half_duplex: begin
				tx_d = cts_i;
				rx_d = !(cts_i || tx_busy_i);
			end
			default: begin
				tx_d = 1'b0;
				rx_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_q <= 1'b0;
			rx_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			rx_q <= rx_d;
		end
	end

	assign tx_en_o = tx_q;
	assign rx_en_o = rx_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	sequence s_last_timeout;
		state_q == smt_pkg::ST_WAIT && timer_expire && !reply_ok && att_q == `SMT_MAX_RETRY;
	endsequence

	sequence s_fail_report;
		done_valid_o && done_fail_o && state_q == smt_pkg::ST_IDLE;
	endsequence

	sequence s_retry_timeout;
		state_q == smt_pkg::ST_WAIT && timer_expire && !reply_ok && att_q != `SMT_MAX_RETRY;
	endsequence

	chk_driver_full_duplex: assert property (driver_mode_i == smt_pkg::always_driven_full_duplex
		|=> tx_en_o && rx_en_o) else $error("full duplex driver dropped");

	chk_driver_cts_keyed: assert property (driver_mode_i == smt_pkg::cts_keyed_driver_mode
		|=> tx_en_o == $past(cts_i) && rx_en_o) else $error("cts_keyed_driver_mode keying wrong");

	chk_rx_off_sending: assert property (driver_mode_i == smt_pkg::cts_keyed_half_duplex && (cts_i || tx_busy_i)
		|=> !rx_en_o && tx_en_o == $past(cts_i)) else $error("two wire receiver not off");

	chk_retry_same_query: assert property (s_retry_timeout
		|=> qry_valid_o && $stable(qry_opcode_o) && $stable(qry_addr_o) && qry_attempt_o == $past(att_q) + 2'h1)
		else $error("retry not resent");

	chk_attempt_bound: assert property (qry_attempt_o <= `SMT_MAX_RETRY)
		else $error("too many retransmissions");

	chk_fail_reported: assert property (s_last_timeout |=> s_fail_report)
		else $error("last timeout not reported");

	chk_encap_param: assert property (state_q == smt_pkg::ST_IDLE && req_valid_i && req_kind_i == smt_pkg::KIND_OTHER
		|=> qry_opcode_o == `SMT_OP_ENCAP && qry_param_o == `SMT_ENCAP_PARAM && qry_valid_o)
		else $error("passthrough not encapsulated");

	chk_gate_reg_addr: assert property (state_q == smt_pkg::ST_IDLE && req_valid_i && !host_mode_i
		&& req_kind_i != smt_pkg::KIND_OTHER && !req_coil_i |=> qry_addr_o == $past(req_addr_i))
		else $error("gate address biased");

	chk_host_reg_addr: assert property (state_q == smt_pkg::ST_IDLE && req_valid_i && host_mode_i
		&& is_reg_op(sel_opcode) |=> qry_addr_o == 16'($past(req_addr_i) + $past(reg_offset_i)))
		else $error("register address wrong");

	chk_host_coil_addr: assert property (state_q == smt_pkg::ST_IDLE && req_valid_i && host_mode_i
		&& is_coil_op(sel_opcode) |=> qry_addr_o
		== 16'((($past(req_addr_i) + $past(reg_offset_i) - 16'h1) << 4) + 16'h1))
		else $error("coil address wrong");

	chk_host_opcode: assert property (state_q == smt_pkg::ST_IDLE && req_valid_i && host_mode_i
		&& req_kind_i == smt_pkg::KIND_READ |=> qry_opcode_o == $past(rd_opcode_i))
		else $error("host read opcode wrong");

	chk_slave_unbiased: assert property (slv_valid_i
		|=> slv_up_valid_o && slv_up_addr_o == $past(slv_addr_i))
		else $error("slave address biased");

endmodule : serial_master_translator
`default_nettype wire

// ===== verification/framer_model.sv
/* Behavioural framer: takes queries late by one cycle, replies after three cycles.
   Assumes the bench sets its knobs only while the translator is idle. */
`timescale 1ns/1ps
`default_nettype none
module framer_model (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       nrst_i,
	// knobs: attempt that gets a good reply, 3 = none
	input  wire logic [1:0] ok_attempt_i,
	input  wire logic       bad_reply_i,
	// query and reply
	input  wire logic       qry_valid_i,
	input  wire logic [1:0] qry_attempt_i,
	output logic            qry_ready_o,
	output logic            rsp_valid_o,
	output logic            rsp_ok_o
);
	logic [3:0] wait_q;
	logic [1:0] att_q;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			qry_ready_o <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_ok_o    <= 1'b0;
			wait_q      <= 4'h0;
			att_q       <= 2'h0;
		end else begin
			qry_ready_o <= qry_valid_i && !qry_ready_o;
			rsp_valid_o <= 1'b0;
			// ok toggles while no reply, so a stale level never reads as valid
			rsp_ok_o    <= ~rsp_ok_o;
			if (qry_valid_i && qry_ready_o) begin
				wait_q <= 4'h3;
				att_q  <= qry_attempt_i;
			end else if (wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
				if (wait_q == 4'h1 && (att_q == ok_attempt_i || bad_reply_i)) begin
					rsp_valid_o <= 1'b1;
					rsp_ok_o    <= (att_q == ok_attempt_i);
				end
			end
		end
	end
endmodule : framer_model
`default_nettype wire

// ===== verification/testbench.sv
/* Self-checking bench for the serial master translator.
   Assumes framer_model on the query side; bench drives all other inputs. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int TICKS = 4;
	logic clk_sys_i, nrst_i, host_mode_i, req_valid_i, req_ready_o, req_coil_i;
	logic [15:0] reg_offset_i, retry_timeout_i, req_addr_i, qry_addr_o, slv_addr_i, slv_up_addr_o;
	logic [7:0] rd_opcode_i, wr_opcode_i, qry_opcode_o, qry_param_o;
	logic [1:0] qry_attempt_o, ok_attempt;
	smt_pkg::driver_mode_type driver_mode_i;
	smt_pkg::kind_type req_kind_i;
	logic done_valid_o, done_fail_o, qry_valid_o, qry_ready_i, rsp_valid_i, rsp_ok_i, bad_reply;
	logic slv_valid_i, slv_up_valid_o, cts_i, tx_busy_i, tx_en_o, rx_en_o;
	int error_cnt, total_checks;

	serial_master_translator #(.TICK_CYCLES(TICKS)) u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.host_mode_i(host_mode_i), .reg_offset_i(reg_offset_i), .rd_opcode_i(rd_opcode_i),
		.wr_opcode_i(wr_opcode_i), .retry_timeout_i(retry_timeout_i), .driver_mode_i(driver_mode_i),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_kind_i(req_kind_i),
		.req_coil_i(req_coil_i), .req_addr_i(req_addr_i), .done_valid_o(done_valid_o),
		.done_fail_o(done_fail_o), .qry_valid_o(qry_valid_o), .qry_ready_i(qry_ready_i),
		.qry_opcode_o(qry_opcode_o), .qry_addr_o(qry_addr_o), .qry_param_o(qry_param_o),
		.qry_attempt_o(qry_attempt_o), .rsp_valid_i(rsp_valid_i), .rsp_ok_i(rsp_ok_i),
		.slv_valid_i(slv_valid_i), .slv_addr_i(slv_addr_i), .slv_up_valid_o(slv_up_valid_o),
		.slv_up_addr_o(slv_up_addr_o), .cts_i(cts_i), .tx_busy_i(tx_busy_i), .tx_en_o(tx_en_o),
		.rx_en_o(rx_en_o));

	framer_model u_framer (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ok_attempt_i(ok_attempt),
		.bad_reply_i(bad_reply), .qry_valid_i(qry_valid_o), .qry_attempt_i(qry_attempt_o),
		.qry_ready_o(qry_ready_i), .rsp_valid_o(rsp_valid_i), .rsp_ok_o(rsp_ok_i));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// sel 0: query up, 1: done pulse, 2: query down; n counts edges waited
	task automatic wait_sig(input int sel, output int n);
		n = 0;
		while ((sel == 0 ? qry_valid_o : sel == 1 ? done_valid_o : !qry_valid_o) !== 1'b1) begin
			@(posedge clk_sys_i);
			#1;
			n++;
			if (n > 60) begin
				error_cnt++;
				$display("ERROR t=%0t wait ran out", $time);
				conclude();
			end
		end
	endtask : wait_sig

	task automatic send(input smt_pkg::kind_type k, input logic c, input logic [15:0] a);
		int n;
		@(posedge clk_sys_i);
		req_valid_i <= 1'b1;
		req_kind_i  <= k;
		req_coil_i  <= c;
		req_addr_i  <= a;
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		#1;
		wait_sig(0, n);
	endtask : send

	task automatic xact(input smt_pkg::kind_type k, input logic c, input logic [15:0] a,
		input logic [7:0] op, input logic [15:0] ea, input logic [7:0] prm, input bit ca);
		int n;
		send(k, c, a);
		chk(req_ready_o, 16'h0, "ready while busy");
		chk(qry_opcode_o, op, "opcode");
		if (ca) begin
			chk(qry_addr_o, ea, "address");
		end
		chk(qry_param_o, prm, "param");
		wait_sig(1, n);
		chk(done_fail_o, 16'h0, "done fail");
	endtask : xact

	function automatic logic [15:0] coil(input logic [15:0] a, input logic [15:0] o);
		return ((a + o - 16'h1) << 4) + 16'h1;
	endfunction : coil

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic test_host_addr;
		logic [7:0] ops[7];
		logic [15:0] offs[3];
		ops  = '{8'h03, 8'h04, 8'h06, 8'h10, 8'h01, 8'h05, 8'h0F};
		offs = '{16'h0000, 16'h01F4, 16'hFFFF};
		host_mode_i <= 1'b1;
		foreach (offs[j]) begin
			foreach (ops[i]) begin
				reg_offset_i <= offs[j];
				rd_opcode_i  <= ops[i];
				wr_opcode_i  <= ops[i];
				if (i < 4) begin
					xact(i[0] ? smt_pkg::KIND_WRITE : smt_pkg::KIND_READ, 1'b1, 16'h0007, ops[i], 16'h0007 + offs[j], 8'h00, 1);
				end else begin
					xact(i[0] ? smt_pkg::KIND_WRITE : smt_pkg::KIND_READ, 1'b0, 16'h0007, ops[i], coil(16'h0007, offs[j]), 8'h00, 1);
				end
			end
		end
		$display("host address test done");
	endtask : test_host_addr

	task automatic test_gate;
		host_mode_i  <= 1'b0;
		reg_offset_i <= 16'h01F4;
		rd_opcode_i  <= 8'h04;
		wr_opcode_i  <= 8'h06;
		xact(smt_pkg::KIND_READ, 1'b0, 16'h0002, 8'h03, 16'h0002, 8'h00, 1);
		xact(smt_pkg::KIND_READ, 1'b1, 16'h0002, 8'h01, coil(16'h0002, 16'h0), 8'h00, 1);
		xact(smt_pkg::KIND_WRITE, 1'b0, 16'h0005, 8'h10, 16'h0005, 8'h00, 1);
		xact(smt_pkg::KIND_WRITE, 1'b1, 16'h0005, 8'h0F, coil(16'h0005, 16'h0), 8'h00, 1);
		xact(smt_pkg::KIND_OTHER, 1'b0, 16'h0005, 8'h11, 16'h0, 8'h01, 0);
		host_mode_i <= 1'b1;
		xact(smt_pkg::KIND_OTHER, 1'b0, 16'h0005, 8'h11, 16'h0, 8'h01, 0);
		$display("gate test done");
	endtask : test_gate

	task automatic test_retry;
		int n;
		ok_attempt <= 2'h3;
		bad_reply  <= 1'b1;
		send(smt_pkg::KIND_READ, 1'b0, 16'h0005);
		for (int i = 0; i < 3; i++) begin
			chk(qry_attempt_o, i[15:0], "attempt");
			wait_sig(2, n);
			if (i < 2) begin
				wait_sig(0, n);
				chk(n[15:0], 16'(2 * TICKS + 1), "retry gap");
			end
		end
		wait_sig(1, n);
		chk(n[15:0], 16'(2 * TICKS + 1), "fail delay");
		chk(done_fail_o, 16'h1, "fail flag");
		ok_attempt <= 2'h1;
		bad_reply  <= 1'b0;
		send(smt_pkg::KIND_WRITE, 1'b0, 16'h0005);
		wait_sig(2, n);
		wait_sig(0, n);
		chk(qry_attempt_o, 16'h1, "second attempt");
		wait_sig(1, n);
		chk(done_fail_o, 16'h0, "late success");
		ok_attempt <= 2'h0;
		$display("retry test done");
	endtask : test_retry

	task automatic test_slave;
		reg_offset_i <= 16'h1234;
		@(posedge clk_sys_i);
		slv_valid_i <= 1'b1;
		slv_addr_i  <= 16'h00AB;
		@(posedge clk_sys_i);
		slv_valid_i <= 1'b0;
		#1;
		chk(slv_up_valid_o, 16'h1, "slave valid");
		chk(slv_up_addr_o, 16'h00AB, "slave addr");
		$display("slave test done");
	endtask : test_slave

	task automatic test_driver;
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 4; k++) begin
				@(posedge clk_sys_i);
				driver_mode_i <= smt_pkg::driver_mode_type'(m[1:0]);
				cts_i         <= k[0];
				tx_busy_i     <= k[1];
				@(posedge clk_sys_i);
				@(posedge clk_sys_i);
				#1;
				chk(tx_en_o, m == 0 ? 16'h1 : m == 3 ? 16'h0 : {15'h0, k[0]}, "tx enable");
				chk(rx_en_o, m == 2 ? {15'h0, !(k[0] || k[1])} : 16'h1, "rx enable");
			end
		end
		$display("driver test done");
	endtask : test_driver

	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		error_cnt = 0;
		total_checks = 0;
		nrst_i = 1'b0;
		{host_mode_i, req_valid_i, req_coil_i, slv_valid_i, cts_i, tx_busy_i, bad_reply} = '0;
		{reg_offset_i, req_addr_i, slv_addr_i, rd_opcode_i, wr_opcode_i, ok_attempt} = '0;
		retry_timeout_i = 16'h0002;
		driver_mode_i = smt_pkg::always_driven_full_duplex;
		req_kind_i = smt_pkg::KIND_READ;
		repeat (10) @(posedge clk_sys_i);
		#1;
		chk(req_ready_o, 16'h1, "reset ready");
		chk(qry_valid_o, 16'h0, "reset query");
		chk(tx_en_o, 16'h0, "reset tx enable");
		chk(rx_en_o, 16'h0, "reset rx enable");
		chk(done_valid_o, 16'h0, "reset done");
		nrst_i <= 1'b1;
		test_host_addr();
		test_gate();
		test_retry();
		test_slave();
		test_driver();
		conclude();
	end
endmodule : testbench
`default_nettype wire
